// *** src/flash_pkg.sv ***
// Constants and types shared by the flash sequencer and its array store
package flash_pkg;
   // ***************************************************
   // Array layout
   // ***************************************************
   localparam int MAIN_BYTES      = 8192;
   localparam int SEG_BYTES       = 512;
   localparam int MAIN_SEGS       = MAIN_BYTES / SEG_BYTES;
   localparam int INFO_SEG_BYTES  = 128;
   localparam int INFO_SEGS       = 2;
   localparam int INFO_BYTES      = INFO_SEG_BYTES * INFO_SEGS;
   localparam int TOTAL_BYTES     = MAIN_BYTES + INFO_BYTES;
   localparam int ADDR_W          = 14;
   localparam int SEG_W           = 4;
   localparam logic [7:0] ERASED  = 8'hff;
   localparam logic [ADDR_W-1:0] INFO_BASE = 14'h2000;
   localparam logic [ADDR_W-1:0] INFO_B_BASE = 14'h2080;
   // ***************************************************
   // Timing and loader password
   // ***************************************************
   localparam int CLK_MHZ         = 50;
   localparam int ERASE_STEP_NS   = 20;
   localparam int ERASE_STEP_CYC  = (ERASE_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam logic [31:0] PASSWORD_DEFAULT = 32'h5a5a_a5a5;
   // ***************************************************
   // Commands and sources
   // ***************************************************
   typedef enum logic [2:0] {
      CMD_NONE, CMD_WRITE_BYTE, CMD_WRITE_WORD, CMD_ERASE_SEG,
      CMD_ERASE_MAIN, CMD_ERASE_INFO_A, CMD_ERASE_INFO_B, CMD_ERASE_ALL
   } cmd_t;
   typedef enum logic [1:0] {SRC_CPU, SRC_DEBUG, SRC_LOADER} src_t;
endpackage

// *** src/flash_store.sv ***
// Flip-flop byte array holding main and information flash
`timescale 1ns/1ns
module flash_store (
   // Clock and reset
   input  wire logic                         clk,
   input  wire logic                         resetn,
   input  wire logic                         ce,
   // Write port
   input  wire logic                         we,
   input  wire logic [flash_pkg::ADDR_W-1:0] waddr,
   input  wire logic [7:0]                   wdata,
   // Read port
   input  wire logic [flash_pkg::ADDR_W-1:0] raddr,
   output logic      [7:0]                   rdata
);
   logic [7:0] mem [flash_pkg::TOTAL_BYTES];
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = mem[raddr];
   end

   // No reset on the array itself: contents are kept, as flash would be
   always_ff @(posedge clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 8'h00;
      end else if (ce) begin
         rdata <= next_rdata;
      end
   end
endmodule

// *** src/flash_segment_program_erase.sv ***
// Flash program and erase sequencer with source selection and loader lock
`timescale 1ns/1ns
module flash_segment_program_erase (
   // Clock, enable, reset
   input  wire logic                         clk,
   input  wire logic                         ce,
   input  wire logic                         resetn,
   // Command port
   input  wire logic                         cmd_valid,
   output logic                              cmd_ready,
   input  flash_pkg::src_t                   cmd_src,
   input  flash_pkg::cmd_t                   cmd_op,
   input  wire logic [flash_pkg::ADDR_W-1:0] cmd_addr,
   input  wire logic [flash_pkg::SEG_W-1:0]  cmd_seg,
   input  wire logic [15:0]                  cmd_wdata,
   input  wire logic                         cmd_ram,
   output logic                              cmd_refused,
   // Loader unlock
   input  wire logic                         pw_valid,
   input  wire logic [31:0]                  pw_value,
   output logic                              loader_unlocked,
   // RAM write path for the loader
   output logic                              ram_we,
   output logic      [flash_pkg::ADDR_W-1:0] ram_addr,
   output logic      [15:0]                  ram_wdata,
   // Read port
   input  wire logic [flash_pkg::ADDR_W-1:0] rd_addr,
   output logic      [7:0]                   rd_data,
   // Status
   output logic                              busy
);
   // ***************************************************
   // Address helpers
   // ***************************************************
   function automatic logic [flash_pkg::ADDR_W-1:0] seg_base(input logic [flash_pkg::SEG_W-1:0] s);
      seg_base = flash_pkg::ADDR_W'(s) << $clog2(flash_pkg::SEG_BYTES);
   endfunction

   function automatic logic is_info(input logic [flash_pkg::ADDR_W-1:0] a);
      is_info = (a >= flash_pkg::INFO_BASE);
   endfunction

   // ***************************************************
   // Sequencer
   // ***************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_WRITE_HI, ST_ERASE} state_t;

   state_t                      state, next_state;
   logic [flash_pkg::ADDR_W-1:0] ptr, next_ptr;
   logic [flash_pkg::ADDR_W-1:0] last, next_last;
   logic [7:0]                  hi_byte, next_hi_byte;
   logic                        unlocked, next_unlocked;
   logic                        refused, next_refused;
   logic                        ram_we_r, next_ram_we;
   logic [flash_pkg::ADDR_W-1:0] ram_addr_r, next_ram_addr;
   logic [15:0]                 ram_wdata_r, next_ram_wdata;
   logic                        we;
   logic [flash_pkg::ADDR_W-1:0] waddr;
   logic [7:0]                  wdata;
   logic                        allowed;

   // Loader needs the password, debug and processor are always let in
   assign allowed   = (cmd_src != flash_pkg::SRC_LOADER) || unlocked;
   assign cmd_ready = (state == ST_IDLE);

   always_comb begin
      next_state     = state;
      next_ptr       = ptr;
      next_last      = last;
      next_hi_byte   = hi_byte;
      next_unlocked  = unlocked;
      next_refused   = 1'b0;
      next_ram_we    = 1'b0;
      next_ram_addr  = ram_addr_r;
      next_ram_wdata = ram_wdata_r;
      we             = 1'b0;
      waddr          = ptr;
      wdata          = flash_pkg::ERASED;
      if (pw_valid) begin
         next_unlocked = (pw_value == flash_pkg::PASSWORD_DEFAULT);
      end
      case (state)
         ST_IDLE: begin
            if (cmd_valid && !allowed) begin
               next_refused = 1'b1;
            end else if (cmd_valid && cmd_src == flash_pkg::SRC_LOADER && cmd_ram) begin
               next_ram_we    = 1'b1;
               next_ram_addr  = cmd_addr;
               next_ram_wdata = cmd_wdata;
            end else if (cmd_valid) begin
               case (cmd_op)
                  flash_pkg::CMD_WRITE_BYTE: begin
                     we    = 1'b1;
                     waddr = cmd_addr;
                     wdata = cmd_wdata[7:0];
                  end
                  flash_pkg::CMD_WRITE_WORD: begin
                     we           = 1'b1;
                     waddr        = {cmd_addr[flash_pkg::ADDR_W-1:1], 1'b0};
                     wdata        = cmd_wdata[7:0];
                     next_ptr     = {cmd_addr[flash_pkg::ADDR_W-1:1], 1'b1};
                     next_hi_byte = cmd_wdata[15:8];
                     next_state   = ST_WRITE_HI;
                  end
                  flash_pkg::CMD_ERASE_SEG: begin
                     next_ptr   = seg_base(cmd_seg);
                     next_last  = seg_base(cmd_seg) + flash_pkg::ADDR_W'(flash_pkg::SEG_BYTES - 1);
                     next_state = ST_ERASE;
                  end
                  flash_pkg::CMD_ERASE_MAIN: begin
                     next_ptr   = '0;
                     next_last  = flash_pkg::INFO_BASE - 14'h0001;
                     next_state = ST_ERASE;
                  end
                  flash_pkg::CMD_ERASE_INFO_A: begin
                     next_ptr   = flash_pkg::INFO_BASE;
                     next_last  = flash_pkg::INFO_B_BASE - 14'h0001;
                     next_state = ST_ERASE;
                  end
                  flash_pkg::CMD_ERASE_INFO_B: begin
                     next_ptr   = flash_pkg::INFO_B_BASE;
                     next_last  = flash_pkg::ADDR_W'(flash_pkg::TOTAL_BYTES - 1);
                     next_state = ST_ERASE;
                  end
                  flash_pkg::CMD_ERASE_ALL: begin
                     next_ptr   = '0;
                     next_last  = flash_pkg::ADDR_W'(flash_pkg::TOTAL_BYTES - 1);
                     next_state = ST_ERASE;
                  end
                  default: begin
                     next_state = ST_IDLE;
                  end
               endcase
            end
         end
         ST_WRITE_HI: begin
            we         = 1'b1;
            waddr      = ptr;
            wdata      = hi_byte;
            next_state = ST_IDLE;
         end
         ST_ERASE: begin
            // One byte per cycle keeps the store a single write port
            we    = 1'b1;
            waddr = ptr;
            wdata = flash_pkg::ERASED;
            if (ptr == last) begin
               next_state = ST_IDLE;
            end else begin
               next_ptr = ptr + 14'h0001;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state       <= ST_IDLE;
         ptr         <= '0;
         last        <= '0;
         hi_byte     <= 8'h00;
         unlocked    <= 1'b0;
         refused     <= 1'b0;
         ram_we_r    <= 1'b0;
         ram_addr_r  <= '0;
         ram_wdata_r <= 16'h0000;
      end else if (ce) begin
         state       <= next_state;
         ptr         <= next_ptr;
         last        <= next_last;
         hi_byte     <= next_hi_byte;
         unlocked    <= next_unlocked;
         refused     <= next_refused;
         ram_we_r    <= next_ram_we;
         ram_addr_r  <= next_ram_addr;
         ram_wdata_r <= next_ram_wdata;
      end
   end

   assign busy            = (state != ST_IDLE);
   assign cmd_refused     = refused;
   assign loader_unlocked = unlocked;
   assign ram_we          = ram_we_r;
   assign ram_addr        = ram_addr_r;
   assign ram_wdata       = ram_wdata_r;

   // ***************************************************
   // Array store
   // ***************************************************
   flash_store u_store (
      .clk    (clk),
      .resetn (resetn),
      .ce     (ce),
      .we     (we && ce),
      .waddr  (waddr),
      .wdata  (wdata),
      .raddr  (rd_addr),
      .rdata  (rd_data)
   );

   // ***************************************************
   // Checks
   // ***************************************************
   sequence erase_start_s;
      state == ST_IDLE && ce && cmd_valid && allowed && !(cmd_src == flash_pkg::SRC_LOADER && cmd_ram)
         && cmd_op == flash_pkg::CMD_ERASE_SEG;
   endsequence

   locked_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state == ST_IDLE && cmd_valid && cmd_src == flash_pkg::SRC_LOADER && !unlocked)
      |=> refused && !ram_we_r) else $error("locked loader command not refused");
   cpu_accept_a: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state == ST_IDLE && cmd_valid && cmd_src == flash_pkg::SRC_CPU) |=> !refused)
      else $error("processor command refused");
   ram_write_a: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state == ST_IDLE && cmd_valid && cmd_src == flash_pkg::SRC_LOADER && unlocked && cmd_ram)
      |=> ram_we_r && ram_wdata_r == $past(cmd_wdata)) else $error("loader ram write lost");
   word_two_a: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state == ST_IDLE && cmd_valid && allowed && !cmd_ram && cmd_op == flash_pkg::CMD_WRITE_WORD)
      |=> state == ST_WRITE_HI ##1 (!ce || state == ST_IDLE)) else $error("word write not two bytes");
   seg_span_a: assert property (@(posedge clk) disable iff (!resetn)
      erase_start_s |=> state == ST_ERASE && last - ptr == flash_pkg::ADDR_W'(flash_pkg::SEG_BYTES - 1))
      else $error("segment span wrong");
   erase_fill_a: assert property (@(posedge clk) disable iff (!resetn)
      (state == ST_ERASE) |-> we && wdata == 8'hff) else $error("erase writes non-blank");
   erase_step_a: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state == ST_ERASE && ptr != last) |=> state == ST_ERASE && ptr == $past(ptr) + 14'h0001)
      else $error("erase skipped a byte");
   info_span_a: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state == ST_IDLE && cmd_valid && allowed && !cmd_ram && cmd_op == flash_pkg::CMD_ERASE_INFO_B)
      |=> ptr == 14'h2080 && last == 14'h20ff) else $error("info B span wrong");
   all_span_a: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state == ST_IDLE && cmd_valid && allowed && !cmd_ram && cmd_op == flash_pkg::CMD_ERASE_ALL)
      |=> ptr == 14'h0000 && last == 14'h20ff) else $error("full erase span wrong");
endmodule

// *** verification/flash_host_model.sv ***
// Host-side model issuing flash commands and loader passwords
`timescale 1ns/1ns
module flash_host_model (
   // Clock
   input  wire logic                         clk,
   // Command port
   output logic                              cmd_valid,
   input  wire logic                         cmd_ready,
   output flash_pkg::src_t                   cmd_src,
   output flash_pkg::cmd_t                   cmd_op,
   output logic      [flash_pkg::ADDR_W-1:0] cmd_addr,
   output logic      [flash_pkg::SEG_W-1:0]  cmd_seg,
   output logic      [15:0]                  cmd_wdata,
   output logic                              cmd_ram,
   // Loader password
   output logic                              pw_valid,
   output logic      [31:0]                  pw_value
);
   logic timed_out = 1'b0;
   initial begin
      cmd_valid = 1'b0;
      cmd_src = flash_pkg::SRC_CPU;
      cmd_op = flash_pkg::CMD_NONE;
      {cmd_addr, cmd_seg, cmd_wdata, cmd_ram} = '0;
      pw_valid = 1'b0;
      pw_value = 32'h0000_0000;
   end
   // ***************************************************
   // Requests held until taken
   // ***************************************************
   task automatic issue(input flash_pkg::src_t s, input flash_pkg::cmd_t op, input logic [13:0] a,
                        input logic [3:0] sg, input logic [15:0] d, input logic r);
      logic rdy = 1'b0;
      int   n = 0;
      @(posedge clk);
      #1;
      cmd_src = s;
      cmd_op = op;
      cmd_addr = a;
      cmd_seg = sg;
      cmd_wdata = d;
      cmd_ram = r;
      cmd_valid = 1'b1;
      while (!rdy && n < 10000) begin
         @(negedge clk);
         rdy = cmd_ready;
         @(posedge clk);
         n++;
      end
      if (!rdy)
         timed_out = 1'b1;
      #1;
      cmd_valid = 1'b0;
      // Released address and data lines must not keep showing the last value
      cmd_addr = ~cmd_addr;
      cmd_wdata = ~cmd_wdata;
   endtask
   task automatic password(input logic [31:0] v);
      @(posedge clk);
      #1;
      pw_valid = 1'b1;
      pw_value = v;
      @(posedge clk);
      #1;
      pw_valid = 1'b0;
      pw_value = ~v;
   endtask
endmodule

// *** verification/flash_segment_program_erase_tb.sv ***
// Self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ns
module flash_segment_program_erase_tb;
   logic                         clk = 1'b0;
   logic                         resetn = 1'b0;
   logic                         ce = 1'b1;
   logic [flash_pkg::ADDR_W-1:0] rd_addr = '0;
   logic                         cmd_valid, cmd_ready, cmd_ram, cmd_refused, pw_valid, loader_unlocked;
   logic                         ram_we, busy;
   flash_pkg::src_t              cmd_src;
   flash_pkg::cmd_t              cmd_op;
   logic [flash_pkg::ADDR_W-1:0] cmd_addr, ram_addr;
   logic [flash_pkg::SEG_W-1:0]  cmd_seg;
   logic [15:0]                  cmd_wdata, ram_wdata;
   logic [31:0]                  pw_value;
   logic [7:0]                   rd_data;
   int                           model [flash_pkg::TOTAL_BYTES];
   int                           unlocked_m = 0;
   int                           mismatches = 0;
   int                           n_compared = 0;
   int                           seed = 7357;
   int len_tab [8] = '{0, 0, 0, flash_pkg::SEG_BYTES, flash_pkg::MAIN_BYTES, flash_pkg::INFO_SEG_BYTES,
                       flash_pkg::INFO_SEG_BYTES, flash_pkg::TOTAL_BYTES};
   int lo_tab [8] = '{0, 0, 0, 0, 0, flash_pkg::MAIN_BYTES, flash_pkg::MAIN_BYTES + flash_pkg::INFO_SEG_BYTES, 0};
   logic [13:0] probe_addr [10] = '{14'h0000, 14'h01ff, 14'h0200, 14'h1dff, 14'h1e00, 14'h1fff,
                                    14'h2000, 14'h207f, 14'h2080, 14'h20ff};
   always #10 clk = ~clk;
   flash_segment_program_erase flash_segment_program_erase_inst (.clk(clk), .ce(ce), .resetn(resetn),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_src(cmd_src), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_seg(cmd_seg), .cmd_wdata(cmd_wdata), .cmd_ram(cmd_ram), .cmd_refused(cmd_refused),
      .pw_valid(pw_valid), .pw_value(pw_value), .loader_unlocked(loader_unlocked), .ram_we(ram_we),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
   flash_host_model host_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_src(cmd_src),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_seg(cmd_seg), .cmd_wdata(cmd_wdata), .cmd_ram(cmd_ram),
      .pw_valid(pw_valid), .pw_value(pw_value));
   // ***************************************************
   // Compare, verdict and command tasks
   // ***************************************************
   task automatic chk_data(input string what, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_flag(input string what, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic run(input flash_pkg::src_t s, input flash_pkg::cmd_t op, input logic [13:0] a,
                      input logic [3:0] sg, input logic [15:0] d, input logic r);
      int   k = 0;
      int   nb = 0;
      int   nref = 0;
      int   nram = 0;
      int   lo = 0;
      logic refuse = (s == flash_pkg::SRC_LOADER) && unlocked_m == 0;
      logic to_ram = (s == flash_pkg::SRC_LOADER) && !refuse && r;
      logic flash_ok = !refuse && !to_ram;
      if (flash_ok && op == flash_pkg::CMD_WRITE_BYTE)
         model[a] = d[7:0];
      if (flash_ok && op == flash_pkg::CMD_WRITE_WORD) begin
         model[{a[13:1], 1'b0}] = d[7:0];
         model[{a[13:1], 1'b1}] = d[15:8];
      end
      lo = (op == flash_pkg::CMD_ERASE_SEG) ? sg * flash_pkg::SEG_BYTES : lo_tab[op];
      for (int i = 0; flash_ok && i < len_tab[op]; i++)
         model[lo + i] = 8'hff;
      host_inst.issue(s, op, a, sg, d, r);
      while (k < 9000 && (busy === 1'b1 || k < 3)) begin
         nb += (busy === 1'b1);
         nref += (cmd_refused === 1'b1);
         nram += (ram_we === 1'b1);
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= 9000 || host_inst.timed_out) begin
         mismatches++;
         conclude();
      end else begin
         chk_data("busy cycles", !flash_ok ? 0 : op == flash_pkg::CMD_WRITE_WORD ? 1 : len_tab[op],
                  nb[15:0]);
         chk_flag("busy idle", 1'b0, busy);
         chk_flag("cmd_ready", 1'b1, cmd_ready);
         chk_data("refused pulses", {15'h0, refuse}, nref[15:0]);
         chk_data("ram pulses", {15'h0, to_ram}, nram[15:0]);
         if (to_ram) begin
            chk_data("ram_addr", {2'b00, a}, {2'b00, ram_addr});
            chk_data("ram_wdata", d, ram_wdata);
         end
      end
   endtask
   task automatic rd_chk(input logic [13:0] a);
      @(posedge clk);
      #1;
      rd_addr = a;
      @(posedge clk);
      #1;
      chk_data("rd_data", model[a][15:0], {8'h00, rd_data});
   endtask
   task automatic probe(input string name);
      foreach (probe_addr[i])
         rd_chk(probe_addr[i]);
      $display("test %s done", name);
   endtask
   // Writes only erased bytes, so programming semantics cannot matter
   task automatic refill();
      foreach (probe_addr[i])
         if (model[probe_addr[i]] == 8'hff)
            run(i % 2 ? flash_pkg::SRC_DEBUG : flash_pkg::SRC_CPU, flash_pkg::CMD_WRITE_BYTE, probe_addr[i],
                4'h0, 16'($random(seed)), 1'b0);
   endtask
   task automatic unlock(input logic [31:0] v);
      host_inst.password(v);
      unlocked_m = (v == flash_pkg::PASSWORD_DEFAULT);
      @(posedge clk);
      #1;
      chk_flag("loader_unlocked", unlocked_m[0], loader_unlocked);
   endtask
   // Low enable must hold the read register and ignore a password attempt
   task automatic freeze_chk(input logic [13:0] a);
      rd_chk(a);
      ce = 1'b0;
      rd_addr = a ^ 14'h0001;
      host_inst.password(~flash_pkg::PASSWORD_DEFAULT);
      chk_data("frozen rd_data", model[a][15:0], {8'h00, rd_data});
      chk_flag("frozen unlock", unlocked_m[0], loader_unlocked);
      ce = 1'b1;
      $display("test freeze done");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1;
      resetn = 1'b1;
      run(flash_pkg::SRC_CPU, flash_pkg::CMD_ERASE_ALL, 14'h0, 4'h0, 16'h0, 1'b0);
      probe("erase all");
      refill();
      probe("byte writes");
      run(flash_pkg::SRC_CPU, flash_pkg::CMD_WRITE_WORD, 14'h0103, 4'h0, 16'($random(seed)), 1'b0);
      rd_chk(14'h0102);
      rd_chk(14'h0103);
      for (int op = 3; op <= 6; op++)
         for (int sg = 0; sg < 16; sg += 15) begin
            run(flash_pkg::SRC_CPU, flash_pkg::cmd_t'(op), 14'h0, 4'(sg), 16'h0, 1'b0);
            probe("erase");
            refill();
         end
      run(flash_pkg::SRC_CPU, flash_pkg::CMD_NONE, 14'h0100, 4'h0, 16'h0, 1'b0);
      run(flash_pkg::SRC_LOADER, flash_pkg::CMD_WRITE_BYTE, 14'h0300, 4'h0, 16'h0012, 1'b0);
      rd_chk(14'h0300);
      unlock(flash_pkg::PASSWORD_DEFAULT ^ 32'h0000_0001);
      unlock(flash_pkg::PASSWORD_DEFAULT);
      freeze_chk(14'h0000);
      run(flash_pkg::SRC_LOADER, flash_pkg::CMD_WRITE_BYTE, 14'h0300, 4'h0, 16'h0034, 1'b0);
      rd_chk(14'h0300);
      run(flash_pkg::SRC_LOADER, flash_pkg::CMD_WRITE_WORD, 14'h0044, 4'h0, 16'($random(seed)), 1'b1);
      unlock(flash_pkg::PASSWORD_DEFAULT ^ 32'h8000_0000);
      run(flash_pkg::SRC_LOADER, flash_pkg::CMD_ERASE_MAIN, 14'h0, 4'h0, 16'h0, 1'b0);
      probe("loader lock");
      conclude();
   end
endmodule
